/* src/line_delay_fifo_pkg.sv */
// line_delay_fifo_pkg.sv: shared constants and types of the line memory link.
// Assumes nothing; both ends and the interface import it.
package line_delay_fifo_pkg;

    // ========================================================================
    // Array geometry
    localparam int              DEPTH      = 5120;
    localparam int              ADDR_W     = 13;
    localparam int              DATA_W     = 8;
    localparam logic [12:0]     PTR_INIT   = 13'h0000;
    localparam logic [12:0]     PTR_STEP   = 13'h0001;

    // ========================================================================
    // Far-end timing
    localparam int              CLK_DIV          = 4;
    localparam int              MIN_LEAD         = 3;
    localparam int              REF_PERIOD_NS    = 20;
    localparam int              HOLD_TIME_MS     = 20;
    localparam int              NS_PER_MS        = 1000000;
    localparam int              HOLD_REF_CYCLES  = HOLD_TIME_MS * NS_PER_MS / REF_PERIOD_NS;
    localparam int              CLEAR_CYCLES     = 1;
    localparam int              HOLD_LINK_CYCLES = HOLD_REF_CYCLES / CLK_DIV - DEPTH
                                                   - CLEAR_CYCLES;

    // ========================================================================
    // Counters and buffer
    localparam int              TOTAL_W    = 16;
    localparam int              IDLE_W     = 20;
    localparam logic [15:0]     TOTAL_ZERO = 16'h0000;
    localparam logic [15:0]     TOTAL_ONE  = 16'h0001;
    localparam logic [19:0]     IDLE_ZERO  = 20'h00000;
    localparam logic [19:0]     IDLE_ONE   = 20'h00001;
    localparam logic [1:0]      BUF_EMPTY  = 2'h0;
    localparam logic [1:0]      BUF_ONE    = 2'h1;
    localparam logic [1:0]      BUF_FULL   = 2'h2;

    // ========================================================================
    // Far-end sequencing
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CLEAR = 2'b01,
        ST_RUN   = 2'b10
    } host_state_t;

endpackage : line_delay_fifo_pkg

/* src/line_delay_if.sv */
// line_delay_if.sv: pins between the line memory and its controlling logic.
// Assumes the host end drives both clocks; the byte output carries an enable.
`timescale 1ns/1ps

interface line_delay_if;
    import line_delay_fifo_pkg::*;

    logic              input_side_clock;
    logic              input_side_enable_n;
    logic              input_pointer_clear_n;
    logic [DATA_W-1:0] input_byte;
    logic              output_side_clock;
    logic              output_side_enable_n;
    logic              output_pointer_clear_n;
    logic [DATA_W-1:0] output_byte;
    logic              output_byte_oe;

    modport device (
        input  input_side_clock, input_side_enable_n, input_pointer_clear_n, input_byte,
        input  output_side_clock, output_side_enable_n, output_pointer_clear_n,
        output output_byte, output_byte_oe
    );

    modport host (
        output input_side_clock, input_side_enable_n, input_pointer_clear_n, input_byte,
        output output_side_clock, output_side_enable_n, output_pointer_clear_n,
        input  output_byte, output_byte_oe
    );

endinterface : line_delay_if

/* src/two_entry_buffer.sv */
// two_entry_buffer.sv: two-word skid buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module two_entry_buffer
    import line_delay_fifo_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // Filling side
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    // Draining side
    output logic                  o_valid,
    output logic      [WIDTH-1:0] o_data,
    input  wire logic             i_ready,
    output logic            [1:0] o_count
);

    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic       [1:0] count;
    logic [WIDTH-1:0] next_head;
    logic [WIDTH-1:0] next_tail;
    logic       [1:0] next_count;
    logic             push;
    logic             pop;

    assign o_ready = (count != BUF_FULL);
    assign o_valid = (count != BUF_EMPTY);
    assign o_data  = head;
    assign o_count = count;
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_comb begin
        next_head  = head;
        next_tail  = tail;
        next_count = count;
        case ({push, pop})
            2'b10: begin
                if (count == BUF_EMPTY) begin
                    next_head = i_data;
                end else begin
                    next_tail = i_data;
                end
                next_count = count + BUF_ONE;
            end
            2'b01: begin
                next_head  = tail;
                next_count = count - BUF_ONE;
            end
            2'b11: begin
                if (count == BUF_ONE) begin
                    next_head = i_data;
                end else begin
                    next_head = tail;
                    next_tail = i_data;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            head  <= '0;
            tail  <= '0;
            count <= BUF_EMPTY;
        end else begin
            head  <= next_head;
            tail  <= next_tail;
            count <= next_count;
        end
    end

endmodule : two_entry_buffer

/* src/line_delay_fifo.sv */
// line_delay_fifo.sv: the line memory itself, the documented device end.
// Holds the dual-clock byte array, both pointers and the commit stage.
// Assumes the far end makes both link clocks and holds each pointer clear
// low over at least one rising edge before it relies on the memory.
`timescale 1ns/1ps

module line_delay_fifo
    import line_delay_fifo_pkg::*;
#(
    parameter int MEM_DEPTH = DEPTH
) (
    // Link to the controlling logic
    line_delay_if.device         link,
    // Status on the input-side clock
    output logic [ADDR_W-1:0]    o_write_pointer,
    output logic                 o_commit_pending,
    // Status on the output-side clock
    output logic [ADDR_W-1:0]    o_read_pointer,
    output logic                 o_output_driving
);

    // ========================================================================
    // Storage and pointer arithmetic

    localparam logic [ADDR_W-1:0] LAST_LOC = ADDR_W'(MEM_DEPTH - 1);

    // The array has no reset; its contents are only what has been committed.
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // Steps a pointer on by one location, back to the start after the last.
    function automatic logic [ADDR_W-1:0] advance(input logic [ADDR_W-1:0] ptr);
        if (ptr == LAST_LOC) begin
            return PTR_INIT;
        end
        return ptr + PTR_STEP;
    endfunction : advance

    // ========================================================================
    // Input side: capture stage

    logic [ADDR_W-1:0] wr_ptr;
    logic              pend_valid;
    logic [ADDR_W-1:0] pend_addr;
    logic [DATA_W-1:0] pend_data;
    logic [ADDR_W-1:0] next_wr_ptr;
    logic              next_pend_valid;
    logic [ADDR_W-1:0] next_pend_addr;
    logic [DATA_W-1:0] next_pend_data;

    // A byte is first latched with its location, and committed on the next
    // rising edge whether or not that cycle is enabled. The producer keeps
    // the clock running for that edge, so the last byte of a burst lands.
    always_comb begin
        next_wr_ptr     = wr_ptr;
        next_pend_valid = 1'b0;
        next_pend_addr  = pend_addr;
        next_pend_data  = pend_data;
        if (!link.input_pointer_clear_n) begin
            next_wr_ptr = PTR_INIT;
        end else if (!link.input_side_enable_n) begin
            next_pend_valid = 1'b1;
            next_pend_addr  = wr_ptr;
            next_pend_data  = link.input_byte;
            next_wr_ptr     = advance(wr_ptr);
        end
    end

    always_ff @(posedge link.input_side_clock) begin
        wr_ptr     <= next_wr_ptr;
        pend_valid <= next_pend_valid;
        pend_addr  <= next_pend_addr;
        pend_data  <= next_pend_data;
    end

    // ========================================================================
    // Input side: commit to the array

    // The held byte enters the array one edge after capture. A clear on the
    // same edge still commits it, because only the pointer is cleared. A
    // location changes only when it is written again, so a byte outlives a
    // full line until the writer comes round to it.
    always_ff @(posedge link.input_side_clock) begin
        if (pend_valid) begin
            mem[pend_addr] <= pend_data;
        end
    end

    assign o_write_pointer  = wr_ptr;
    assign o_commit_pending = pend_valid;

    // ========================================================================
    // Output side: read stage

    logic [ADDR_W-1:0] rd_ptr;
    logic [DATA_W-1:0] q;
    logic              q_oe;
    logic [ADDR_W-1:0] next_rd_ptr;
    logic [DATA_W-1:0] next_q;
    logic              next_q_oe;

    // The read takes the array word on the first edge of its cycle. A word
    // whose commit has not yet happened reads back as the old contents,
    // which is why the reader must trail the writer.
    always_comb begin
        next_rd_ptr = rd_ptr;
        next_q      = q;
        next_q_oe   = 1'b0;
        if (!link.output_pointer_clear_n) begin
            next_rd_ptr = PTR_INIT;
        end else if (!link.output_side_enable_n) begin
            next_q      = mem[rd_ptr];
            next_q_oe   = 1'b1;
            next_rd_ptr = advance(rd_ptr);
        end
    end

    // With the enable and the clear high the pointer holds; with the enable high the outputs let go.
    always_ff @(posedge link.output_side_clock) begin
        rd_ptr <= next_rd_ptr;
        q      <= next_q;
        q_oe   <= next_q_oe;
    end

    // ========================================================================
    // Output pins and status

    assign link.output_byte    = q;
    assign link.output_byte_oe = q_oe;
    assign o_read_pointer      = rd_ptr;
    assign o_output_driving    = q_oe;

endmodule : line_delay_fifo

/* src/line_delay_host.sv */
// line_delay_host.sv: controlling logic that drives the line memory.
// Makes both link clocks from i_ref_clk, feeds bytes in, reads bytes out.
// Assumes DIV is even and at least 4 and the memory end is on the link.
`timescale 1ns/1ps

module line_delay_host
    import line_delay_fifo_pkg::*;
#(
    parameter int DIV        = CLK_DIV,
    parameter int HOLD_LIMIT = HOLD_LINK_CYCLES
) (
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_srst,
    // Control and status
    input  wire logic              i_start,
    input  wire logic              i_mode,
    input  wire logic [ADDR_W-1:0] i_delay,
    output logic                   o_busy,
    output logic                   o_hold_fault,
    // Write stream
    input  wire logic              i_wr_valid,
    input  wire logic [DATA_W-1:0] i_wr_data,
    output logic                   o_wr_ready,
    // Read stream
    output logic                   o_rd_valid,
    output logic      [DATA_W-1:0] o_rd_data,
    input  wire logic              i_rd_ready,
    // Link to the memory
    line_delay_if.host             link
);

    // ========================================================================
    // Link clock divider

    localparam int              PH_W      = $clog2(DIV);
    localparam logic [PH_W-1:0] PH_LAST   = PH_W'(DIV - 1);
    localparam logic [PH_W-1:0] PH_HALF   = PH_W'(DIV / 2);
    localparam logic [PH_W-1:0] PH_SAMPLE = PH_W'(DIV / 2 - 1);
    localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(HOLD_LIMIT);

    logic [PH_W-1:0] ph;
    logic [PH_W-1:0] next_ph;
    logic            link_clk;
    logic            next_link_clk;
    logic            tick;
    logic            sample;

    // Out of reset the clock runs on without pause, so the edge that commits a last byte
    // always follows, disabled cycle or not.
    always_comb begin
        next_ph       = (ph == PH_LAST) ? '0 : ph + PH_W'(1);
        next_link_clk = (next_ph >= PH_HALF);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ph       <= '0;
            link_clk <= 1'b0;
        end else begin
            ph       <= next_ph;
            link_clk <= next_link_clk;
        end
    end

    assign tick   = (ph == PH_LAST);
    assign sample = (ph == PH_SAMPLE);

    // ========================================================================
    // Returned byte, two flip-flops before use

    logic [DATA_W-1:0] q_meta;
    logic [DATA_W-1:0] q_sync;
    logic              oe_meta;
    logic              oe_sync;

    always_ff @(posedge i_ref_clk) begin
        q_meta  <= link.output_byte;
        q_sync  <= q_meta;
        oe_meta <= link.output_byte_oe;
        oe_sync <= oe_meta;
    end

    // ========================================================================
    // Buffers on both streams

    host_state_t        state;
    logic               wb_valid;
    logic [DATA_W-1:0]  wb_data;
    logic         [1:0] rb_count;
    logic               wr_go;
    logic               rd_go;
    logic               rd_push;
    logic               read_room;
    logic [TOTAL_W-1:0] wr_total;
    logic [TOTAL_W-1:0] rd_total;
    logic [TOTAL_W-1:0] lead;
    logic [TOTAL_W-1:0] need;
    logic               mode_r;
    logic  [ADDR_W-1:0] delay_r;
    logic               rd_en_n;

    two_entry_buffer #(.WIDTH(DATA_W)) u_in_buf (
        .i_clk(i_ref_clk), .i_srst(i_srst), .i_valid(i_wr_valid), .i_data(i_wr_data),
        .o_ready(o_wr_ready), .o_valid(wb_valid), .o_data(wb_data), .i_ready(wr_go),
        .o_count()
    );

    two_entry_buffer #(.WIDTH(DATA_W)) u_out_buf (
        .i_clk(i_ref_clk), .i_srst(i_srst), .i_valid(rd_push), .i_data(q_sync),
        .o_ready(), .o_valid(o_rd_valid), .o_data(o_rd_data), .i_ready(i_rd_ready),
        .o_count(rb_count)
    );

    // A read is issued only when the output buffer can hold it and the one
    // still in flight, so a stalled consumer never loses a byte.
    assign read_room = (rb_count == BUF_EMPTY) || ((rb_count == BUF_ONE) && rd_en_n);
    assign lead      = wr_total - rd_total;
    assign need      = (mode_r && (TOTAL_W'(delay_r) > TOTAL_W'(MIN_LEAD))) ?
                       TOTAL_W'(delay_r) : TOTAL_W'(MIN_LEAD);
    assign wr_go     = tick && wb_valid && (state != ST_IDLE)
                       && (lead < TOTAL_W'(DEPTH));
    assign rd_go     = tick && (state == ST_RUN) && read_room && (lead >= need);
    assign rd_push   = sample && oe_sync && (state == ST_RUN);

    // ========================================================================
    // Sequencer and link drive

    host_state_t        next_state;
    logic               start_req, next_start_req, next_mode;
    logic  [ADDR_W-1:0] gap, next_gap, next_delay;
    logic [TOTAL_W-1:0] next_wr_total, next_rd_total;
    logic               wr_en_n, next_wr_en_n, next_rd_en_n;
    logic               wclr_n, next_wclr_n, rclr_n, next_rclr_n;
    logic  [DATA_W-1:0] wdata, next_wdata;
    logic  [IDLE_W-1:0] wr_idle, next_wr_idle, rd_idle, next_rd_idle;
    logic               fault, next_fault;

    always_comb begin
        next_state     = state;
        next_start_req = start_req | i_start;
        next_mode      = mode_r;
        next_delay     = delay_r;
        next_gap       = gap;
        next_wr_total  = wr_total;
        next_rd_total  = rd_total;
        next_wr_en_n   = wr_en_n;
        next_rd_en_n   = rd_en_n;
        next_wclr_n    = wclr_n;
        next_rclr_n    = rclr_n;
        next_wdata     = wdata;
        next_wr_idle   = wr_idle;
        next_rd_idle   = rd_idle;
        next_fault     = fault | (wr_idle > IDLE_LIMIT) | (rd_idle > IDLE_LIMIT);
        if (tick) begin
            next_wclr_n  = 1'b1;
            next_rclr_n  = 1'b1;
            next_wr_en_n = !wr_go;
            next_rd_en_n = !rd_go;
            if (wr_go) begin
                next_wdata    = wb_data;
                next_wr_total = wr_total + TOTAL_ONE;
            end
            if (rd_go) begin
                next_rd_total = rd_total + TOTAL_ONE;
            end
            unique case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        next_start_req = i_start;
                        next_wclr_n    = 1'b0;
                        next_wr_total  = TOTAL_ZERO;
                        next_rd_total  = TOTAL_ZERO;
                        next_mode      = i_mode;
                        next_delay     = i_delay;
                        next_gap       = '0;
                        next_wr_idle   = IDLE_ZERO;
                        next_rd_idle   = IDLE_ZERO;
                        if (i_mode || (i_delay == '0)) begin
                            next_rclr_n = 1'b0;
                            next_state  = ST_RUN;
                        end else begin
                            next_state  = ST_CLEAR;
                        end
                    end
                end
                ST_CLEAR: begin
                    next_gap = gap + PTR_STEP;
                    if ((gap + PTR_STEP) == delay_r) begin
                        next_rclr_n   = 1'b0;
                        next_rd_total = TOTAL_ZERO;
                        next_state    = ST_RUN;
                    end
                end
                ST_RUN: begin
                    next_wr_idle = wr_go ? IDLE_ZERO : wr_idle + IDLE_ONE;
                    next_rd_idle = rd_go ? IDLE_ZERO : rd_idle + IDLE_ONE;
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // The clears sit low through reset so the first link edge clears both pointers.
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state     <= ST_IDLE;
            start_req <= 1'b0;
            mode_r    <= 1'b0;
            delay_r   <= '0;
            gap       <= '0;
            wr_total  <= TOTAL_ZERO;
            rd_total  <= TOTAL_ZERO;
            wr_en_n   <= 1'b1;
            rd_en_n   <= 1'b1;
            wclr_n    <= 1'b0;
            rclr_n    <= 1'b0;
            wdata     <= '0;
            wr_idle   <= IDLE_ZERO;
            rd_idle   <= IDLE_ZERO;
            fault     <= 1'b0;
        end else begin
            state     <= next_state;
            start_req <= next_start_req;
            mode_r    <= next_mode;
            delay_r   <= next_delay;
            gap       <= next_gap;
            wr_total  <= next_wr_total;
            rd_total  <= next_rd_total;
            wr_en_n   <= next_wr_en_n;
            rd_en_n   <= next_rd_en_n;
            wclr_n    <= next_wclr_n;
            rclr_n    <= next_rclr_n;
            wdata     <= next_wdata;
            wr_idle   <= next_wr_idle;
            rd_idle   <= next_rd_idle;
            fault     <= next_fault;
        end
    end

    assign link.input_side_clock       = link_clk;
    assign link.output_side_clock      = link_clk;
    assign link.input_side_enable_n    = wr_en_n;
    assign link.input_pointer_clear_n  = wclr_n;
    assign link.input_byte             = wdata;
    assign link.output_side_enable_n   = rd_en_n;
    assign link.output_pointer_clear_n = rclr_n;
    assign o_busy                      = (state != ST_IDLE);
    assign o_hold_fault                = fault;

endmodule : line_delay_host

/* test/line_delay_checker.sv */
// Checker of the link between the line memory and its controlling logic.
// Assumes both link clocks stand still while i_srst is high.
`timescale 1ns/1ps

module line_delay_checker
    import line_delay_fifo_pkg::*;
(
    // Reference side
    input wire logic              i_ref_clk,
    input wire logic              i_srst,
    // Link
    input wire logic              input_side_clock,
    input wire logic              input_side_enable_n,
    input wire logic              input_pointer_clear_n,
    input wire logic [DATA_W-1:0] input_byte,
    input wire logic              output_side_clock,
    input wire logic              output_side_enable_n,
    input wire logic              output_pointer_clear_n,
    input wire logic [DATA_W-1:0] output_byte,
    input wire logic              output_byte_oe
);
    // ====================
    // Shadow array and pointers.
    logic [DATA_W-1:0] mem [DEPTH];
    logic [ADDR_W-1:0] wp, rp, lead;
    logic [DATA_W-1:0] exp_byte;
    always_ff @(posedge input_side_clock)
        if (!input_pointer_clear_n) wp <= PTR_INIT;
        else if (!input_side_enable_n) begin
            mem[wp] <= input_byte;
            wp <= (wp == ADDR_W'(DEPTH - 1)) ? PTR_INIT : wp + PTR_STEP;
        end
    always_ff @(posedge output_side_clock)
        if (!output_pointer_clear_n) rp <= PTR_INIT;
        else if (!output_side_enable_n) begin
            exp_byte <= mem[rp];
            rp <= (rp == ADDR_W'(DEPTH - 1)) ? PTR_INIT : rp + PTR_STEP;
        end
    always_comb lead = (wp >= rp) ? wp - rp : wp + ADDR_W'(DEPTH) - rp;
    // ====================
    // Link rules.
    chk_float_off: assert property (@(posedge output_side_clock) disable iff (i_srst)
        output_side_enable_n |=> !output_byte_oe) else $error("output driven while disabled");
    chk_read_drives: assert property (@(posedge output_side_clock) disable iff (i_srst)
        !output_side_enable_n && output_pointer_clear_n |=> output_byte_oe)
        else $error("read not driven");
    chk_clear_wins: assert property (@(posedge output_side_clock) disable iff (i_srst)
        !output_pointer_clear_n |=> !output_byte_oe) else $error("output driven in clear");
    chk_read_data: assert property (@(posedge output_side_clock) disable iff (i_srst)
        output_byte_oe |-> output_byte == exp_byte) else $error("wrong byte read");
    chk_read_lead: assert property (@(posedge output_side_clock) disable iff (i_srst)
        !output_side_enable_n && output_pointer_clear_n |-> lead > 13'h0001)
        else $error("read too close to write");
    chk_power_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        $fell(i_srst) |-> !input_pointer_clear_n && !output_pointer_clear_n)
        else $error("no clear after reset");
    chk_write_setup: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        $rose(input_side_clock) |-> $stable(input_byte) && $stable(input_side_enable_n)
        && $stable(input_pointer_clear_n)) else $error("write inputs move at edge");
    chk_out_stands: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !$rose(output_side_clock) |-> $stable(output_byte_oe)
        && (!output_byte_oe || $stable(output_byte))) else $error("output moved off edge");
endmodule : line_delay_checker

/* test/line_delay_fifo_test.sv */
// Bench: host and line memory on one link, byte streams checked end to end.
// Assumes the host makes both link clocks from i_ref_clk.
`timescale 1ns/1ps

module line_delay_fifo_test;
    import line_delay_fifo_pkg::*;
    logic              i_ref_clk = 1'h0, i_srst = 1'h1, i_start = 1'h0, i_mode = 1'h0;
    logic              i_wr_valid = 1'h0, i_rd_ready = 1'h0;
    logic [ADDR_W-1:0] i_delay = 13'h0000;
    logic [DATA_W-1:0] i_wr_data = 8'h00, o_rd_data;
    logic              o_busy, o_hold_fault, o_wr_ready, o_rd_valid, pend, drv;
    logic [ADDR_W-1:0] wptr, rptr;
    int                error_cnt = 0, checks = 0, gap = 0, seen = 0;
    line_delay_if lk ();
    line_delay_host #(.HOLD_LIMIT(40)) i_line_delay_host (.i_ref_clk(i_ref_clk),
        .i_srst(i_srst), .i_start(i_start), .i_mode(i_mode), .i_delay(i_delay),
        .o_busy(o_busy), .o_hold_fault(o_hold_fault), .i_wr_valid(i_wr_valid),
        .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready), .link(lk));
    line_delay_fifo i_line_delay_fifo (.link(lk), .o_write_pointer(wptr), .o_commit_pending(pend),
        .o_read_pointer(rptr), .o_output_driving(drv));
    line_delay_checker i_line_delay_checker (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
        .input_side_clock(lk.input_side_clock), .input_side_enable_n(lk.input_side_enable_n),
        .input_pointer_clear_n(lk.input_pointer_clear_n), .input_byte(lk.input_byte),
        .output_side_clock(lk.output_side_clock), .output_byte(lk.output_byte),
        .output_side_enable_n(lk.output_side_enable_n), .output_byte_oe(lk.output_byte_oe),
        .output_pointer_clear_n(lk.output_pointer_clear_n));
    always #10 i_ref_clk = ~i_ref_clk;
    // Link cycles from the write clear to the read clear.
    always @(posedge lk.input_side_clock) begin
        gap <= lk.input_pointer_clear_n ? gap + 1 : 0;
        if (!lk.output_pointer_clear_n && lk.input_pointer_clear_n) seen <= gap + 1;
    end
    // ====================
    // Tasks.
    function automatic logic [DATA_W-1:0] pat(input int i);
        return DATA_W'(i * 37 + 5);
    endfunction : pat
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Words are paced below the slowest read rate, so no enable idles past the limit.
    task automatic push(input int n);
        @(negedge i_ref_clk);
        for (int i = 0; i < n; i++) begin
            i_wr_valid = 1'h1;
            i_wr_data = pat(i);
            while (o_wr_ready !== 1'h1) @(negedge i_ref_clk);
            @(negedge i_ref_clk);
            i_wr_valid = 1'h0;
            repeat (7) @(negedge i_ref_clk);
        end
    endtask : push
    task automatic pull(input int k);
        for (int j = 0, t = 1; j < k; t++) begin
            @(negedge i_ref_clk);
            i_rd_ready = (t % 4 != 0);
            if (o_rd_valid === 1'h1 && i_rd_ready) begin
                check({8'h00, o_rd_data}, {8'h00, pat(j)});
                j++;
            end
        end
    endtask : pull
    task automatic run(input logic mode, input logic [ADDR_W-1:0] dly, input int n, input int k);
        i_srst = 1'h1;
        repeat (20) @(negedge i_ref_clk);
        i_srst = 1'h0;
        @(negedge i_ref_clk);
        check({15'h0000, o_hold_fault}, 16'h0000);
        i_mode = mode;
        i_delay = dly;
        i_start = 1'h1;
        @(negedge i_ref_clk);
        i_start = 1'h0;
        fork
            push(n);
            pull(n - k + 1);
        join
        check({15'h0000, o_busy}, 16'h0001);
        check({15'h0000, o_hold_fault}, 16'h0000);
        if (!mode) check(16'(seen), 16'(dly));
        repeat (400) @(negedge i_ref_clk);
        check({15'h0000, o_hold_fault}, 16'h0001);
        check({3'h0, wptr}, 16'(n % DEPTH));
        check({3'h0, rptr}, 16'((n - k + 1) % DEPTH));
        check({14'h0000, pend, drv}, 16'h0000);
        $display("stream test in mode %0d done", mode);
    endtask : run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // ====================
    // Tests and watchdog.
    initial begin
        run(1'h0, 13'h0005, 5130, 3);
        run(1'h1, 13'h0008, 20, 8);
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : line_delay_fifo_test
